// ### tisr_pkg.sv
// package: register map, field positions and carrier types of the tag irq block
//
// Summary of operation
// - mask register 08h gates eight low flags
// - mask register 09h gates eight high flags
// - masking blocks the line, flags still set
// - masks load from nonvolatile configuration bits
// - power-up flag on power events and commands
// - wake flag on entering selected state
// - sleep flag on sleep request received
// - flags for reader write and read
// - receive-end flag when frame buffered
// - transmit-end and field-exit flags
// - flags clear on power-up, default, read
// - receive-start flag at 0Bh bit 7
// - coding, parity, crc errors set flags
// - buffer error flag on over/underflow
// - host programming done sets flag
// - protected or missing address write flagged
// - access-control abort of host operation flagged
// - 0Ch holds unread count and invalid bit
// - 0Dh holds underflow and overflow bits
// - 0Dh bits 5..3 show handshake flags
// - 0Eh last reader address, FFh while updating
// - fixed major and minor revision codes
`default_nettype none

package tisr_pkg;

   // ***************************************************************
   // register offsets
   // ***************************************************************
   localparam logic [5:0] ADDR_MASK_LOW   = 6'h08;
   localparam logic [5:0] ADDR_MASK_HIGH  = 6'h09;
   localparam logic [5:0] ADDR_FLAGS_LOW  = 6'h0a;
   localparam logic [5:0] ADDR_FLAGS_HIGH = 6'h0b;
   localparam logic [5:0] ADDR_LEVEL      = 6'h0c;
   localparam logic [5:0] ADDR_FIFO_FLAGS = 6'h0d;
   localparam logic [5:0] ADDR_LAST_LOC   = 6'h0e;
   localparam logic [5:0] ADDR_REV_MAJOR  = 6'h1e;
   localparam logic [5:0] ADDR_REV_MINOR  = 6'h1f;

   // ***************************************************************
   // field positions
   // ***************************************************************
   localparam int LVL_INVALID_BIT = 7;
   localparam int FF_BUSY_BIT     = 5;
   localparam int FF_RDATA_BIT    = 4;
   localparam int FF_HDATA_BIT    = 3;
   localparam int FF_UNDER_BIT    = 1;
   localparam int FF_OVER_BIT     = 0;

   // ***************************************************************
   // values after reset and constants
   // ***************************************************************
   localparam logic [7:0] FLAGS_RESET    = 8'h00;
   localparam logic [7:0] STATUS_RESET   = 8'h00;
   localparam logic [7:0] LOC_UPDATING   = 8'hff;
   localparam logic [7:0] READ_UNMAPPED  = 8'h00;
   // arbitrary neutral revision values
   localparam logic [7:0] REV_MAJOR_VAL  = 8'h01;
   localparam logic [7:0] REV_MINOR_VAL  = 8'h01;

   // ***************************************************************
   // event carriers, bit 7 first; buffer state carrier, bit 11 first
   // ***************************************************************
   typedef struct packed {
      logic power_up;      // bit 7
      logic wake_select;   // bit 6
      logic sleep_req;     // bit 5
      logic reader_wrote;  // bit 4
      logic reader_read;   // bit 3
      logic rx_end;        // bit 2
      logic tx_end;        // bit 1
      logic field_exit;    // bit 0
   } tisr_low_ev_t;

   typedef struct packed {
      logic rx_start;      // bit 7
      logic frame_err;     // bit 6
      logic parity_err;    // bit 5
      logic crc_err;       // bit 4
      logic fifo_fault;    // bit 3
      logic host_prog_ok;  // bit 2
      logic mem_acc_err;   // bit 1
      logic acc_ctl_err;   // bit 0
   } tisr_high_ev_t;

   typedef struct packed {
      logic [5:0] unread_count;
      logic       count_invalid;
      logic       underflow;
      logic       overflow;
      logic       reader_side_busy;
      logic       reader_data_waiting;
      logic       host_data_ready;
   } tisr_fifo_st_t;

endpackage

`default_nettype wire

// ### tisr_top.sv
// module: tag interrupt flags, masks, buffer status and revision registers
`default_nettype none

module tisr_top
   import tisr_pkg::*;
(
   // clock and reset
   input  wire logic          core_clk,
   input  wire logic          rst,
   // nonvolatile configuration defaults for the masks
   input  wire logic [7:0]    nv_mask_low,
   input  wire logic [7:0]    nv_mask_high,
   // device commands, one-cycle pulses
   input  wire logic          cmd_set_default,
   input  wire logic          cmd_clear_buffer,
   // one-cycle event pulses from the tag logic
   input  wire tisr_low_ev_t  ev_low,
   input  wire tisr_high_ev_t ev_high,
   // buffer state from the buffer logic, same clock
   input  wire tisr_fifo_st_t fifo_st,
   // reader memory access: start pulse, done pulse with address
   input  wire logic          loc_update_start,
   input  wire logic          loc_update_done,
   input  wire logic [7:0]    loc_update_addr,
   // register port from the serial slave
   input  wire logic          reg_rd,
   input  wire logic          reg_wr,
   input  wire logic [5:0]    reg_addr,
   input  wire logic [7:0]    reg_wdata,
   output var  logic [7:0]    reg_rdata,
   // interrupt line to the host
   output var  logic          irq_out
);

   // ***************************************************************
   // mask registers
   // ***************************************************************
   logic [7:0] mask_low_q, mask_low_d;
   logic [7:0] mask_high_q, mask_high_d;
   logic       loaded_q, loaded_d;

   always_comb begin
      mask_low_d  = mask_low_q;
      mask_high_d = mask_high_q;
      loaded_d    = 1'b1;
      // defaults caught after reset release, also on set default
      if (!loaded_q || cmd_set_default) begin
         mask_low_d  = nv_mask_low;
         mask_high_d = nv_mask_high;
      end else if (reg_wr && reg_addr == ADDR_MASK_LOW) begin
         mask_low_d  = reg_wdata;
      end else if (reg_wr && reg_addr == ADDR_MASK_HIGH) begin
         mask_high_d = reg_wdata;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         mask_low_q  <= FLAGS_RESET;
         mask_high_q <= FLAGS_RESET;
         loaded_q    <= 1'b0;
      end else begin
         mask_low_q  <= mask_low_d;
         mask_high_q <= mask_high_d;
         loaded_q    <= loaded_d;
      end
   end

   // ***************************************************************
   // flag registers
   // ***************************************************************
   logic [7:0] flags_low_q, flags_low_d;
   logic [7:0] flags_high_q, flags_high_d;
   logic       rd_low, rd_high;

   assign rd_low  = reg_rd && reg_addr == ADDR_FLAGS_LOW;
   assign rd_high = reg_rd && reg_addr == ADDR_FLAGS_HIGH;

   always_comb begin
      flags_low_d  = flags_low_q;
      flags_high_d = flags_high_q;
      if (cmd_set_default) begin
         flags_low_d  = FLAGS_RESET;
         flags_high_d = FLAGS_RESET;
      end
      if (rd_low) begin
         flags_low_d  = FLAGS_RESET;
      end
      if (rd_high) begin
         flags_high_d = FLAGS_RESET;
      end
      // set beats clear so no event is lost; masks never block this
      flags_low_d  = flags_low_d | ev_low;
      flags_high_d = flags_high_d | ev_high;
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         flags_low_q  <= FLAGS_RESET;
         flags_high_q <= FLAGS_RESET;
      end else begin
         flags_low_q  <= flags_low_d;
         flags_high_q <= flags_high_d;
      end
   end

   // ***************************************************************
   // buffer status and last reader location
   // ***************************************************************
   logic [7:0] level_q, level_d;
   logic [7:0] fflags_q, fflags_d;
   logic [7:0] loc_q, loc_d;

   always_comb begin
      level_d = STATUS_RESET;
      fflags_d = STATUS_RESET;
      level_d[5:0] = fifo_st.unread_count;
      level_d[LVL_INVALID_BIT] = fifo_st.count_invalid;
      // underflow and overflow sticky until clear buffer or set default
      fflags_d[FF_UNDER_BIT] = fflags_q[FF_UNDER_BIT]
                               | fifo_st.underflow;
      fflags_d[FF_OVER_BIT]  = fflags_q[FF_OVER_BIT]
                               | fifo_st.overflow;
      fflags_d[FF_BUSY_BIT]  = fifo_st.reader_side_busy;
      fflags_d[FF_RDATA_BIT] = fifo_st.reader_data_waiting;
      fflags_d[FF_HDATA_BIT] = fifo_st.host_data_ready;
      loc_d = loc_q;
      if (loc_update_start) begin
         loc_d = LOC_UPDATING;
      end
      if (loc_update_done) begin
         loc_d = loc_update_addr;
      end
      if (cmd_set_default || cmd_clear_buffer) begin
         level_d  = STATUS_RESET;
         fflags_d = STATUS_RESET;
         loc_d    = STATUS_RESET;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         level_q  <= STATUS_RESET;
         fflags_q <= STATUS_RESET;
         loc_q    <= STATUS_RESET;
      end else begin
         level_q  <= level_d;
         fflags_q <= fflags_d;
         loc_q    <= loc_d;
      end
   end

   // ***************************************************************
   // read data and interrupt line
   // ***************************************************************
   logic [7:0] rdata_d;
   logic       irq_d;

   always_comb begin
      unique case (reg_addr)
         ADDR_MASK_LOW:   rdata_d = mask_low_q;
         ADDR_MASK_HIGH:  rdata_d = mask_high_q;
         ADDR_FLAGS_LOW:  rdata_d = flags_low_q;
         ADDR_FLAGS_HIGH: rdata_d = flags_high_q;
         ADDR_LEVEL:      rdata_d = level_q;
         ADDR_FIFO_FLAGS: rdata_d = fflags_q;
         ADDR_LAST_LOC:   rdata_d = loc_q;
         ADDR_REV_MAJOR:  rdata_d = REV_MAJOR_VAL;
         ADDR_REV_MINOR:  rdata_d = REV_MINOR_VAL;
         default:         rdata_d = READ_UNMAPPED;
      endcase
      if (!reg_rd) begin
         rdata_d = reg_rdata;
      end
      // mask bit set means that flag does not drive the line
      irq_d = |(flags_low_d & ~mask_low_d)
              | |(flags_high_d & ~mask_high_d);
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         reg_rdata <= READ_UNMAPPED;
         irq_out   <= 1'b0;
      end else begin
         reg_rdata <= rdata_d;
         irq_out   <= irq_d;
      end
   end

   // ***************************************************************
   // assertions
   // ***************************************************************
   property p_flag_sets;
      @(posedge core_clk) disable iff (rst)
         ev_low.rx_end |=> flags_low_q[2];
   endproperty
   a_flag_sets: assert property (p_flag_sets)
      else $error("rx end flag not set");

   property p_read_clears;
      @(posedge core_clk) disable iff (rst)
         (rd_high && ev_high == '0) |=> flags_high_q == FLAGS_RESET;
   endproperty
   a_read_clears: assert property (p_read_clears)
      else $error("high flags not cleared by read");

   property p_masked_sets;
      @(posedge core_clk) disable iff (rst)
         (ev_high.fifo_fault && mask_high_q[3] && !cmd_set_default
          && !reg_wr) |=> flags_high_q[3];
   endproperty
   a_masked_sets: assert property (p_masked_sets)
      else $error("masked flag not set");

   property p_irq_line;
      @(posedge core_clk) disable iff (rst)
         ##1 irq_out == (|(flags_low_q & ~mask_low_q)
                        | |(flags_high_q & ~mask_high_q));
   endproperty
   a_irq_line: assert property (p_irq_line)
      else $error("interrupt line mismatch");

   property p_loc_busy;
      @(posedge core_clk) disable iff (rst)
         (loc_update_start && !loc_update_done && !cmd_set_default
          && !cmd_clear_buffer) |=> loc_q == LOC_UPDATING;
   endproperty
   a_loc_busy: assert property (p_loc_busy)
      else $error("location not FFh while updating");

   property p_clear_buffer;
      @(posedge core_clk) disable iff (rst)
         cmd_clear_buffer |=> (fflags_q == STATUS_RESET
                               && loc_q == STATUS_RESET);
   endproperty
   a_clear_buffer: assert property (p_clear_buffer)
      else $error("status not cleared");

   property p_overflow_sticky;
      @(posedge core_clk) disable iff (rst)
         (fflags_q[FF_OVER_BIT] && !cmd_set_default && !cmd_clear_buffer)
         |=> fflags_q[FF_OVER_BIT];
   endproperty
   a_overflow_sticky: assert property (p_overflow_sticky)
      else $error("overflow lost");

   property p_mask_write;
      @(posedge core_clk) disable iff (rst)
         (loaded_q && !cmd_set_default && reg_wr
          && reg_addr == ADDR_MASK_LOW) |=> mask_low_q == $past(reg_wdata);
   endproperty
   a_mask_write: assert property (p_mask_write)
      else $error("mask write lost");

   property p_rev_read;
      @(posedge core_clk) disable iff (rst)
         (reg_rd && reg_addr == ADDR_REV_MAJOR) |=> reg_rdata == REV_MAJOR_VAL;
   endproperty
   a_rev_read: assert property (p_rev_read)
      else $error("major revision wrong");

   property p_rev_minor;
      @(posedge core_clk) disable iff (rst)
         (reg_rd && reg_addr == ADDR_REV_MINOR) |=> reg_rdata == REV_MINOR_VAL;
   endproperty
   a_rev_minor: assert property (p_rev_minor)
      else $error("minor revision wrong");

   // an event landing on the clearing read must survive it
   property p_set_beats_clear;
      @(posedge core_clk) disable iff (rst)
         (rd_low && ev_low.field_exit) |=> flags_low_q[0];
   endproperty
   a_set_beats_clear: assert property (p_set_beats_clear)
      else $error("event lost to read clear");

   property p_low_read_clears;
      @(posedge core_clk) disable iff (rst)
         (rd_low && ev_low == '0) |=> flags_low_q == FLAGS_RESET;
   endproperty
   a_low_read_clears: assert property (p_low_read_clears)
      else $error("low flags not cleared by read");

   property p_default_clears;
      @(posedge core_clk) disable iff (rst)
         (cmd_set_default && ev_low == '0 && ev_high == '0)
         |=> (flags_low_q == FLAGS_RESET && flags_high_q == FLAGS_RESET);
   endproperty
   a_default_clears: assert property (p_default_clears)
      else $error("flags not cleared by set default");

   property p_default_reload;
      @(posedge core_clk) disable iff (rst)
         cmd_set_default |=> (mask_low_q == $past(nv_mask_low)
                              && mask_high_q == $past(nv_mask_high));
   endproperty
   a_default_reload: assert property (p_default_reload)
      else $error("masks not reloaded on set default");

   property p_mask_high_write;
      @(posedge core_clk) disable iff (rst)
         (loaded_q && !cmd_set_default && reg_wr
          && reg_addr == ADDR_MASK_HIGH) |=> mask_high_q == $past(reg_wdata);
   endproperty
   a_mask_high_write: assert property (p_mask_high_write)
      else $error("high mask write lost");

   property p_masked_low;
      @(posedge core_clk) disable iff (rst)
         (ev_low.tx_end && mask_low_q[1]) |=> flags_low_q[1];
   endproperty
   a_masked_low: assert property (p_masked_low)
      else $error("masked low flag not set");

   property p_low_sets;
      @(posedge core_clk) disable iff (rst)
         ev_low != '0 |=> (~flags_low_q & $past(ev_low)) == '0;
   endproperty
   a_low_sets: assert property (p_low_sets)
      else $error("low event flag not set");

   property p_high_sets;
      @(posedge core_clk) disable iff (rst)
         ev_high != '0 |=> (~flags_high_q & $past(ev_high)) == '0;
   endproperty
   a_high_sets: assert property (p_high_sets)
      else $error("high event flag not set");

   property p_level_live;
      @(posedge core_clk) disable iff (rst)
         (!cmd_set_default && !cmd_clear_buffer)
         |=> level_q == {$past(fifo_st.count_invalid), 1'b0,
                         $past(fifo_st.unread_count)};
   endproperty
   a_level_live: assert property (p_level_live)
      else $error("buffer level does not follow buffer");

   property p_level_cleared;
      @(posedge core_clk) disable iff (rst)
         cmd_clear_buffer |=> level_q == STATUS_RESET;
   endproperty
   a_level_cleared: assert property (p_level_cleared)
      else $error("buffer level not cleared");

   property p_handshake_live;
      @(posedge core_clk) disable iff (rst)
         (!cmd_set_default && !cmd_clear_buffer)
         |=> (fflags_q[FF_BUSY_BIT] == $past(fifo_st.reader_side_busy)
              && fflags_q[FF_RDATA_BIT] == $past(fifo_st.reader_data_waiting)
              && fflags_q[FF_HDATA_BIT] == $past(fifo_st.host_data_ready));
   endproperty
   a_handshake_live: assert property (p_handshake_live)
      else $error("handshake bits do not follow buffer");

   property p_underflow_sticky;
      @(posedge core_clk) disable iff (rst)
         (fflags_q[FF_UNDER_BIT] && !cmd_set_default && !cmd_clear_buffer)
         |=> fflags_q[FF_UNDER_BIT];
   endproperty
   a_underflow_sticky: assert property (p_underflow_sticky)
      else $error("underflow lost");

   property p_loc_done;
      @(posedge core_clk) disable iff (rst)
         (loc_update_done && !cmd_set_default && !cmd_clear_buffer)
         |=> loc_q == $past(loc_update_addr);
   endproperty
   a_loc_done: assert property (p_loc_done)
      else $error("reader address not taken");

endmodule // tisr_top

`default_nettype wire

// ### tisr_host.sv
// host microcontroller model driving the register port of the tag irq block
`default_nettype none

module tisr_host
   import tisr_pkg::*;
(
   // clock
   input  wire logic       core_clk,
   // register port towards the device
   output var  logic       reg_rd,
   output var  logic       reg_wr,
   output var  logic [5:0] reg_addr,
   output var  logic [7:0] reg_wdata,
   input  wire logic [7:0] reg_rdata
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      reg_rd    = 1'b0;
      reg_wr    = 1'b0;
      reg_addr  = 6'h3f;
      reg_wdata = 8'h00;
   end

   // ***************************************************************
   // one byte access, held until the taking edge
   // ***************************************************************
   task automatic access(input logic w, input logic [5:0] a,
                         input logic [7:0] d, output logic [7:0] q);
      @(posedge core_clk);
      reg_rd    <= ~w;
      reg_wr    <= w;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_rd    <= 1'b0;
      reg_wr    <= 1'b0;
      // idle address and data are scrambled, never left looking valid
      reg_addr  <= ~a;
      reg_wdata <= ~d;
      #1;
      q = reg_rdata;
   endtask

endmodule // tisr_host

`default_nettype wire

// ### tisr_top_test.sv
// self-checking bench for the tag interrupt and status registers
`default_nettype none

module tisr_top_test
   import tisr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   localparam logic [7:0] NV_LOW  = 8'hf0;
   localparam logic [7:0] NV_HIGH = 8'h0f;
   // second set of defaults, proves masks follow the inputs
   localparam logic [7:0] NV_RELOAD_LOW  = 8'h3c;
   localparam logic [7:0] NV_RELOAD_HIGH = 8'hc3;

   logic          core_clk;
   logic          rst;
   logic [7:0]    nv_low;
   logic [7:0]    nv_high;
   logic          cmd_set_default;
   logic          cmd_clear_buffer;
   tisr_low_ev_t  ev_low;
   tisr_high_ev_t ev_high;
   tisr_fifo_st_t fifo_st;
   logic          loc_update_start;
   logic          loc_update_done;
   logic [7:0]    loc_update_addr;
   logic          reg_rd;
   logic          reg_wr;
   logic [5:0]    reg_addr;
   logic [7:0]    reg_wdata;
   logic [7:0]    reg_rdata;
   logic          irq_out;
   int            fail_count;
   int            samples_checked;
   int            cycles;

   tisr_top u_dut (
      .core_clk(core_clk), .rst(rst),
      .nv_mask_low(nv_low), .nv_mask_high(nv_high),
      .cmd_set_default(cmd_set_default),
      .cmd_clear_buffer(cmd_clear_buffer),
      .ev_low(ev_low), .ev_high(ev_high), .fifo_st(fifo_st),
      .loc_update_start(loc_update_start),
      .loc_update_done(loc_update_done),
      .loc_update_addr(loc_update_addr),
      .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .irq_out(irq_out));

   tisr_host u_host (
      .core_clk(core_clk), .reg_rd(reg_rd), .reg_wr(reg_wr),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

   // ***************************************************************
   // checking and closing
   // ***************************************************************
   task automatic complete_run();
      if (fail_count == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic chk8(input string n, input logic [7:0] e,
                       input logic [7:0] g);
      samples_checked++;
      if (g !== e) begin
         fail_count++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic chk1(input string n, input logic e, input logic g);
      samples_checked++;
      if (g !== e) begin
         fail_count++;
         $display("unexpected %s expected %b seen %b", n, e, g);
      end
   endtask

   // ***************************************************************
   // stimulus helpers
   // ***************************************************************
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      logic [7:0] q;
      u_host.access(1'b1, a, d, q);
   endtask

   task automatic rd(input logic [5:0] a, input logic [7:0] e);
      logic [7:0] q;
      u_host.access(1'b0, a, 8'h00, q);
      chk8($sformatf("reg %h", a), e, q);
   endtask

   task automatic ev(input logic [7:0] lo, input logic [7:0] hi);
      @(posedge core_clk);
      ev_low  <= tisr_low_ev_t'(lo);
      ev_high <= tisr_high_ev_t'(hi);
      @(posedge core_clk);
      ev_low  <= '0;
      ev_high <= '0;
      #1;
   endtask

   task automatic cmd(input logic dflt, input logic clr);
      @(posedge core_clk);
      cmd_set_default  <= dflt;
      cmd_clear_buffer <= clr;
      @(posedge core_clk);
      cmd_set_default  <= 1'b0;
      cmd_clear_buffer <= 1'b0;
   endtask

   // every flag alone: line rises, read returns it, read clears it
   task automatic flag_walk(input logic hi);
      logic [7:0] b;
      for (int i = 0; i < 8; i++) begin
         b = 8'h01 << i;
         ev(hi ? 8'h00 : b, hi ? b : 8'h00);
         chk1("irq raised", 1'b1, irq_out);
         rd(hi ? ADDR_FLAGS_HIGH : ADDR_FLAGS_LOW, b);
         chk1("irq after read", 1'b0, irq_out);
         rd(hi ? ADDR_FLAGS_HIGH : ADDR_FLAGS_LOW, 8'h00);
      end
   endtask

   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   // hang guard, the whole sequence needs well under a thousand cycles
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         fail_count++;
         complete_run();
      end
   end

   initial begin
      rst = 1'b1; cmd_set_default = 1'b0; cmd_clear_buffer = 1'b0;
      ev_low = '0; ev_high = '0; fifo_st = '0;
      loc_update_start = 1'b0; loc_update_done = 1'b0;
      loc_update_addr = 8'h00;
      fail_count = 0; samples_checked = 0;
      nv_low = NV_LOW;
      nv_high = NV_HIGH;
      repeat (10) @(posedge core_clk);
      rst <= 1'b0;
      repeat (2) @(posedge core_clk);
      rd(ADDR_MASK_LOW, NV_LOW);
      rd(ADDR_MASK_HIGH, NV_HIGH);
      rd(ADDR_FLAGS_LOW, FLAGS_RESET);
      rd(ADDR_FLAGS_HIGH, FLAGS_RESET);
      rd(ADDR_LEVEL, STATUS_RESET);
      rd(ADDR_FIFO_FLAGS, STATUS_RESET);
      rd(ADDR_LAST_LOC, STATUS_RESET);
      wr(ADDR_REV_MAJOR, 8'h5a);
      rd(ADDR_REV_MAJOR, REV_MAJOR_VAL);
      rd(ADDR_REV_MINOR, REV_MINOR_VAL);
      rd(6'h12, READ_UNMAPPED);
      wr(ADDR_MASK_LOW, 8'h5a);
      rd(ADDR_MASK_LOW, 8'h5a);
      wr(ADDR_MASK_HIGH, 8'ha5);
      rd(ADDR_MASK_HIGH, 8'ha5);
      wr(ADDR_MASK_LOW, 8'h00);
      wr(ADDR_MASK_HIGH, 8'h00);
      flag_walk(1'b0);
      flag_walk(1'b1);
      flag_walk(1'b1);
      // masked events still latch, unmasked neighbour still fires
      wr(ADDR_MASK_LOW, 8'hfe);
      wr(ADDR_MASK_HIGH, 8'hff);
      ev(8'h02, 8'h08);
      chk1("irq masked", 1'b0, irq_out);
      ev(8'h01, 8'h00);
      chk1("irq unmasked", 1'b1, irq_out);
      rd(ADDR_FLAGS_HIGH, 8'h08);
      rd(ADDR_FLAGS_LOW, 8'h03);
      // buffer status and sticky error bits
      @(posedge core_clk);
      fifo_st <= tisr_fifo_st_t'(12'habf);
      rd(ADDR_LEVEL, 8'haa);
      rd(ADDR_FIFO_FLAGS, 8'h3b);
      @(posedge core_clk);
      fifo_st <= tisr_fifo_st_t'(12'h007);
      rd(ADDR_FIFO_FLAGS, 8'h3b);
      cmd(1'b0, 1'b1);
      rd(ADDR_FIFO_FLAGS, 8'h38);
      rd(ADDR_LEVEL, 8'h00);
      // reader address tracking
      @(posedge core_clk);
      loc_update_start <= 1'b1;
      @(posedge core_clk);
      loc_update_start <= 1'b0;
      rd(ADDR_LAST_LOC, LOC_UPDATING);
      @(posedge core_clk);
      loc_update_done <= 1'b1;
      loc_update_addr <= 8'h9c;
      @(posedge core_clk);
      loc_update_done <= 1'b0;
      loc_update_addr <= 8'h63;
      rd(ADDR_LAST_LOC, 8'h9c);
      cmd(1'b0, 1'b1);
      rd(ADDR_LAST_LOC, 8'h00);
      // set default wipes pending flags and reloads masks
      wr(ADDR_MASK_LOW, 8'h00);
      ev(8'h80, 8'h01);
      chk1("irq before default", 1'b1, irq_out);
      @(posedge core_clk);
      nv_low  <= NV_RELOAD_LOW;
      nv_high <= NV_RELOAD_HIGH;
      cmd(1'b1, 1'b0);
      rd(ADDR_FLAGS_LOW, 8'h00);
      rd(ADDR_FLAGS_HIGH, 8'h00);
      chk1("irq after default", 1'b0, irq_out);
      rd(ADDR_MASK_LOW, NV_RELOAD_LOW);
      rd(ADDR_MASK_HIGH, NV_RELOAD_HIGH);
      // event on the very edge of the clearing read: set wins
      fork
         ev(8'h01, 8'h00);
         rd(ADDR_FLAGS_LOW, 8'h00);
      join
      chk1("irq set over clear", 1'b1, irq_out);
      rd(ADDR_FLAGS_LOW, 8'h01);
      chk1("irq after late read", 1'b0, irq_out);
      complete_run();
   end

endmodule // tisr_top_test

`default_nettype wire
